/* File: verilog/cips_pkg.sv */
// Constants for the CPU interrupt priority status block: register map, field
// positions, implemented-bit masks and reset values.
// Assumes a 32-bit AXI4-Lite bus with 16-bit registers in the low half-word; the source priority register uses all 32 bits.
package cips_pkg;
  localparam int NSRC = 8;
  localparam int AW = 16;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [AW-1:0] IDX_ICTL1 = 16'h08C0;
  localparam logic [AW-1:0] IDX_ICTL2 = 16'h08C2;
  localparam logic [AW-1:0] IDX_ICTL3 = 16'h08C4;
  localparam logic [AW-1:0] IDX_ICTL4 = 16'h08C6;
  localparam logic [AW-1:0] IDX_PEND = 16'h08C8;
  localparam logic [AW-1:0] IDX_STATUS_WORD = 16'h0900;
  localparam logic [AW-1:0] IDX_CORE_CTL = 16'h0901;
  localparam logic [AW-1:0] IDX_SRC_PRIO = 16'h0902;
  localparam logic [AW-1:0] IDX_EVT_STATUS = 16'h0903;
  localparam logic [AW-1:0] IDX_EVT_CLEAR = 16'h0904;
  localparam logic [AW-1:0] IDX_EVT_ENABLE = 16'h0905;
  // Implemented bits of each register; all others read zero and ignore writes.
  localparam logic [15:0] MASK_ICTL1 = 16'hFFFE;
  localparam logic [15:0] MASK_ICTL2 = 16'hE007;
  localparam logic [15:0] MASK_ICTL3 = 16'h0030;
  localparam logic [15:0] MASK_ICTL4 = 16'h0001;
  localparam logic [15:0] MASK_CORE_CTL = 16'h0008;
  localparam logic [15:0] RST_ICTL1 = 16'h0000;
  localparam logic [15:0] RST_ICTL2 = 16'h8000;
  localparam logic [15:0] RST_ICTL3 = 16'h0000;
  localparam logic [15:0] RST_ICTL4 = 16'h0000;
  localparam logic [15:0] RST_PEND = 16'h0000;
  localparam logic [15:0] RST_CORE_CTL = 16'h0000;
  localparam logic [2:0] RST_CPU_PRIO = 3'h0;
  // Field positions.
  localparam int NEST_DIS_BIT = 15;
  localparam int GIE_BIT = 15;
  localparam int CPU_PRIO_LSB = 5;
  localparam int CPU_PRIO_UPPER_BIT = 3;
  localparam int PEND_LEVEL_LSB = 8;
  localparam int PEND_VECTOR_LSB = 0;
  localparam int PRIO_FIELD_W = 4;
  // Event bits of the sticky status register.
  localparam int NEVT = 2;
  localparam int EVT_FORWARD = 0;
  localparam int EVT_BLOCKED_WRITE = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cips_pkg

/* File: verilog/cips_axil_slave.sv */
// AXI4-Lite slave front end: accepts address and data in either order,
// presents one-cycle register access strobes and returns the responses.
// Assumes the register file answers reads combinationally from rd_addr.
`timescale 1ns/1ps
module cips_axil_slave
  import cips_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic rd_req_q;
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  // Both halves held and no response outstanding: the write happens now.
  assign wr_en = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      rd_req_q <= 1'b0;
      rd_addr <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      rd_req_q <= ar_hs;
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        rd_addr <= s_axi_araddr;
      end
      if (rd_req_q) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_err ? 32'h00000000 : rd_data;
        s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : cips_axil_slave

/* File: verilog/cips_prio_arb.sv */
// Combinational priority selector: finds the pending source with the highest
// priority; on a tie the lowest source index wins.
// Assumes requests and priorities come from logic on the same clock.
`timescale 1ns/1ps
module cips_prio_arb
  import cips_pkg::*;
(
  input wire logic [NSRC-1:0] req,
  input wire logic [NSRC*PRIO_FIELD_W-1:0] prio,
  output logic found,
  output logic [PRIO_FIELD_W-1:0] best_prio,
  output logic [7:0] best_index
);
  logic [NSRC:0] chain_found;
  logic [PRIO_FIELD_W-1:0] chain_prio [NSRC+1];
  logic [7:0] chain_index [NSRC+1];

  assign chain_found[NSRC] = 1'b0;
  assign chain_prio[NSRC] = '0;
  assign chain_index[NSRC] = 8'h00;

  // Scanning from the top index down lets a lower index replace an equal one.
  // A priority of zero never takes part, so it works as a per-source disable.
  for (genvar i = NSRC - 1; i >= 0; i--) begin : g_scan
    wire [PRIO_FIELD_W-1:0] p = prio[i*PRIO_FIELD_W +: PRIO_FIELD_W];
    wire take = req[i] && (p != '0) && (!chain_found[i+1] || p >= chain_prio[i+1]);
    assign chain_found[i] = chain_found[i+1] | take;
    assign chain_prio[i] = take ? p : chain_prio[i+1];
    assign chain_index[i] = take ? 8'(i) : chain_index[i+1];
  end

  assign found = chain_found[0];
  assign best_prio = chain_prio[0];
  assign best_index = chain_index[0];
endmodule : cips_prio_arb

/* File: verilog/cips_top.sv */
// Interrupt priority controller: control registers, CPU priority level,
// pending report, forwarding to the core and event interrupt, on AXI4-Lite.
// Assumes src_req and core_ack come from logic on aclk; the core pulses
// core_ack for one cycle when it takes the forwarded interrupt.
`timescale 1ns/1ps
module cips_top
  import cips_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NSRC-1:0] src_req,
  input wire logic core_ack,
  output logic core_irq_q,
  output logic [3:0] core_level_q,
  output logic [7:0] core_vector_q,
  output logic [3:0] cpu_priority_q,
  output logic irq_q
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_err;
  logic rd_err;

  logic [15:0] interrupt_control_1_q;
  logic [15:0] interrupt_control_2_q;
  logic [15:0] interrupt_control_3_q;
  logic [15:0] interrupt_control_4_q;
  logic [15:0] pending_interrupt_report_q;
  logic [15:0] core_control_register_q;
  logic [2:0] cpu_priority_low_bits_q;
  logic [NSRC*PRIO_FIELD_W-1:0] src_prio_q;
  logic [NEVT-1:0] evt_status_q;
  logic [NEVT-1:0] evt_enable_q;
  logic core_irq_d;

  cips_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Byte-lane merge that also keeps unimplemented bits at zero.
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
    merge16 = ((old_v & ~lanes) | (new_v[15:0] & lanes)) & mask;
  endfunction : merge16

  // Word-aligned index decode; low address bits select nothing.
  wire [AW-1:0] wr_idx = {2'h0, wr_addr[AW-1:2]};
  wire [AW-1:0] rd_idx = {2'h0, rd_addr[AW-1:2]};
  wire wr_ictl1 = wr_en && wr_idx == IDX_ICTL1;
  wire wr_ictl2 = wr_en && wr_idx == IDX_ICTL2;
  wire wr_ictl3 = wr_en && wr_idx == IDX_ICTL3;
  wire wr_ictl4 = wr_en && wr_idx == IDX_ICTL4;
  wire wr_status_word = wr_en && wr_idx == IDX_STATUS_WORD;
  wire wr_core_ctl = wr_en && wr_idx == IDX_CORE_CTL;
  wire wr_src_prio = wr_en && wr_idx == IDX_SRC_PRIO;
  wire wr_evt_clear = wr_en && wr_idx == IDX_EVT_CLEAR;
  wire wr_evt_enable = wr_en && wr_idx == IDX_EVT_ENABLE;
  wire wr_ro = wr_idx == IDX_PEND || wr_idx == IDX_EVT_STATUS;
  wire wr_known = wr_ictl1 | wr_ictl2 | wr_ictl3 | wr_ictl4 | wr_status_word | wr_core_ctl |
                  wr_src_prio | wr_evt_clear | wr_evt_enable;
  // Writes to the read-only report and status registers complete quietly.
  assign wr_err = !(wr_known || wr_ro);

  wire nesting_disable = interrupt_control_1_q[NEST_DIS_BIT];
  wire global_irq_enable = interrupt_control_2_q[GIE_BIT];
  wire cpu_priority_upper_bit = core_control_register_q[CPU_PRIO_UPPER_BIT];
  wire [3:0] eff_priority = {cpu_priority_upper_bit, cpu_priority_low_bits_q};
  wire [15:0] cpu_status_word = {8'h00, cpu_priority_low_bits_q, 5'h00};
  wire prio_write_lanes = wr_strb[0];
  wire prio_write_ok = wr_status_word && prio_write_lanes && !nesting_disable;
  wire prio_write_blocked = wr_status_word && prio_write_lanes && nesting_disable;

  // Read multiplexer; unimplemented bits are already zero in each register.
  wire [15:0] rd_ictl = rd_idx == IDX_ICTL1 ? interrupt_control_1_q :
                        rd_idx == IDX_ICTL2 ? interrupt_control_2_q :
                        rd_idx == IDX_ICTL3 ? interrupt_control_3_q :
                        rd_idx == IDX_ICTL4 ? interrupt_control_4_q :
                        rd_idx == IDX_PEND ? pending_interrupt_report_q :
                        rd_idx == IDX_STATUS_WORD ? cpu_status_word :
                        rd_idx == IDX_CORE_CTL ? core_control_register_q :
                        rd_idx == IDX_EVT_STATUS ? {14'h0000, evt_status_q} :
                        rd_idx == IDX_EVT_ENABLE ? {14'h0000, evt_enable_q} : 16'h0000;
  assign rd_data = rd_idx == IDX_SRC_PRIO ? src_prio_q : {16'h0000, rd_ictl};
  assign rd_err = !(rd_idx == IDX_ICTL1 || rd_idx == IDX_ICTL2 || rd_idx == IDX_ICTL3 ||
                    rd_idx == IDX_ICTL4 || rd_idx == IDX_PEND || rd_idx == IDX_STATUS_WORD ||
                    rd_idx == IDX_CORE_CTL || rd_idx == IDX_SRC_PRIO ||
                    rd_idx == IDX_EVT_STATUS || rd_idx == IDX_EVT_ENABLE ||
                    rd_idx == IDX_EVT_CLEAR);

  logic arb_found;
  logic [PRIO_FIELD_W-1:0] arb_prio;
  logic [7:0] arb_index;

  cips_prio_arb u_arb (
    .req(src_req),
    .prio(src_prio_q),
    .found(arb_found),
    .best_prio(arb_prio),
    .best_index(arb_index)
  );

  // Source priorities are user levels; a value at or below the effective level
  // is held back, so level 7 and every level with the upper bit set block all.
  // A source field above 7 must not slip past level 7, so level 7 gates all.
  wire level_seven = cpu_priority_low_bits_q == 3'h7;
  wire user_allowed = global_irq_enable && !cpu_priority_upper_bit && !level_seven;
  wire prio_beats = arb_prio > eff_priority;
  assign core_irq_d = arb_found && user_allowed && prio_beats;
  wire take = core_irq_q && core_ack;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_control_1_q <= RST_ICTL1;
      interrupt_control_2_q <= RST_ICTL2;
      interrupt_control_3_q <= RST_ICTL3;
      interrupt_control_4_q <= RST_ICTL4;
      core_control_register_q <= RST_CORE_CTL;
      src_prio_q <= '0;
    end else begin
      if (wr_ictl1) begin
        interrupt_control_1_q <= merge16(interrupt_control_1_q, wr_data, wr_strb, MASK_ICTL1);
      end
      if (wr_ictl2) begin
        interrupt_control_2_q <= merge16(interrupt_control_2_q, wr_data, wr_strb, MASK_ICTL2);
      end
      if (wr_ictl3) begin
        interrupt_control_3_q <= merge16(interrupt_control_3_q, wr_data, wr_strb, MASK_ICTL3);
      end
      if (wr_ictl4) begin
        interrupt_control_4_q <= merge16(interrupt_control_4_q, wr_data, wr_strb, MASK_ICTL4);
      end
      if (wr_core_ctl) begin
        core_control_register_q <= merge16(core_control_register_q, wr_data, wr_strb,
                                           MASK_CORE_CTL);
      end
      if (wr_src_prio) begin
        for (int b = 0; b < 4; b++) begin
          if (wr_strb[b]) begin
            src_prio_q[b*8 +: 8] <= wr_data[b*8 +: 8];
          end
        end
      end
    end
  end

  // Taking an interrupt loads the CPU level with the low three bits of the taken priority even with
  // nesting disabled; only software writes are locked out then.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_priority_low_bits_q <= RST_CPU_PRIO;
    end else if (take) begin
      cpu_priority_low_bits_q <= core_level_q[2:0];
    end else if (prio_write_ok) begin
      cpu_priority_low_bits_q <= wr_data[CPU_PRIO_LSB +: 3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_irq_q <= 1'b0;
      core_level_q <= 4'h0;
      core_vector_q <= 8'h00;
      pending_interrupt_report_q <= RST_PEND;
      cpu_priority_q <= 4'h0;
    end else begin
      core_irq_q <= core_irq_d;
      core_level_q <= core_irq_d ? arb_prio : 4'h0;
      core_vector_q <= core_irq_d ? arb_index : 8'h00;
      pending_interrupt_report_q <= core_irq_d ?
        {4'h0, arb_prio, arb_index} : 16'h0000;
      cpu_priority_q <= eff_priority;
    end
  end

  // Sticky events: a set in the same cycle as its clear wins.
  wire [NEVT-1:0] evt_set = {prio_write_blocked, core_irq_d & ~core_irq_q};
  wire [NEVT-1:0] evt_clr = wr_evt_clear && wr_strb[0] ? wr_data[NEVT-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_status_q <= '0;
      evt_enable_q <= '0;
      irq_q <= 1'b0;
    end else begin
      evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
      if (wr_evt_enable && wr_strb[0]) begin
        evt_enable_q <= wr_data[NEVT-1:0];
      end
      irq_q <= |(((evt_status_q & ~evt_clr) | evt_set) &
                 (wr_evt_enable && wr_strb[0] ? wr_data[NEVT-1:0] : evt_enable_q));
    end
  end
endmodule : cips_top

/* File: dv/cips_assertions.sv */
// Checker for the interrupt priority block; sees only ports of cips_top.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module cips_assertions
  import cips_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic core_ack,
  input wire logic core_irq_q,
  input wire logic [3:0] core_level_q,
  input wire logic [7:0] core_vector_q,
  input wire logic [3:0] cpu_priority_q,
  input wire logic irq_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] ack_lvl_q;
  // Remembers the level taken at the last ack, to compare once it lands.
  always_ff @(posedge aclk) begin
    if (core_irq_q && core_ack) ack_lvl_q <= core_level_q[2:0];
  end
  sequence s_ack;
    core_irq_q && core_ack;
  endsequence
  sequence s_upper_held;
    cpu_priority_q[3] [*2];
  endsequence
  sequence s_top_user_level;
    (cpu_priority_q == 4'h7) [*2];
  endsequence
  a_upper_blocks_all: assert property (s_upper_held |-> !core_irq_q)
    else $error("forward while upper priority bit set");
  a_level_seven_blocks: assert property (s_top_user_level |-> !core_irq_q)
    else $error("user forward at level seven");
  a_ack_loads_level: assert property (s_ack |-> ##[1:2] cpu_priority_q[2:0] == ack_lvl_q)
    else $error("ack did not load cpu level");
  a_forward_above_level: assert property ($rose(core_irq_q) |-> core_level_q > cpu_priority_q)
    else $error("forward not above cpu level");
  a_forward_nonzero: assert property (core_irq_q |-> core_level_q != 4'h0)
    else $error("forward with level zero");
  a_idle_zero_report: assert property (!core_irq_q |-> core_level_q == 4'h0 && core_vector_q == 8'h00)
    else $error("level or vector nonzero while idle");
  a_reset_quiet: assert property ($rose(aresetn) |-> !core_irq_q && !irq_q && cpu_priority_q == 4'h0)
    else $error("outputs not cleared by reset");
  a_read_answer_time: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
endmodule : cips_assertions

bind cips_top cips_assertions chk_u (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .core_ack(core_ack),
  .core_irq_q(core_irq_q),
  .core_level_q(core_level_q),
  .core_vector_q(core_vector_q),
  .cpu_priority_q(cpu_priority_q),
  .irq_q(irq_q)
);

/* File: dv/cips_core_model.sv */
// Behavioural processor core: takes each forwarded interrupt still raised after a set delay.
// Assumes core_irq_q and the ack share aclk; the ack is a one-cycle pulse.
`timescale 1ns/1ps
module cips_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en,
  input wire logic [1:0] delay,
  input wire logic irq,
  output logic ack
);
  initial begin
    ack = 1'b0;
    forever begin
      @(posedge aclk);
      if (aresetn && en && irq) begin
        repeat (delay) @(posedge aclk);
        // A forward withdrawn while we waited is not taken.
        if (irq) begin
          ack <= 1'b1;
          @(posedge aclk);
          ack <= 1'b0;
          // Let the new level land so one interrupt is never taken twice.
          repeat (2) @(posedge aclk);
        end
      end
    end
  end
endmodule : cips_core_model

/* File: dv/testbench.sv */
// Self-checking bench for cips_top with a behavioural core on the far side.
// Assumes byte addresses of four times the register index.
`timescale 1ns/1ps
module testbench
  import cips_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, cpu_priority_q, core_level_q, pr [8];
  logic [1:0] bresp, rresp, delay;
  logic [7:0] src_req, core_vector_q;
  logic core_ack, core_irq_q, irq_q, en;
  int failures, cmp_count;
  cips_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .src_req(src_req), .core_ack(core_ack), .core_irq_q(core_irq_q),
    .core_level_q(core_level_q), .core_vector_q(core_vector_q),
    .cpu_priority_q(cpu_priority_q), .irq_q(irq_q));
  cips_core_model core_u (.aclk(aclk), .aresetn(aresetn), .en(en), .delay(delay),
    .irq(core_irq_q), .ack(core_ack));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic conclude();
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang();
    failures++;
    $display("ERROR %0t bus answer missing", $time);
    conclude();
  endtask : hang
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n >= 50) hang();
    @(posedge aclk);
  endtask : wr
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    araddr <= a; arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n >= 50) hang();
    chk({rdata[31:2], rresp}, {e[31:2], r});
    chk(rdata, e);
  endtask : rd_chk
  function automatic logic fwd(input logic [3:0] p, input logic [2:0] l);
    return p > {1'b0, l};
  endfunction : fwd
  function automatic logic [15:0] ctl_mask(input int i);
    return i == 0 ? MASK_ICTL1 : i == 1 ? MASK_ICTL2 : i == 2 ? MASK_ICTL3 : MASK_ICTL4;
  endfunction : ctl_mask
  initial begin
    repeat (50000) @(posedge aclk);
    hang();
  end
  initial begin
    logic [31:0] pw;
    logic [2:0] lvl, k;
    logic f;
    int n;
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0; awaddr = 16'h0000;
    araddr = 16'h0000; wdata = 32'h0; wstrb = 4'h0; src_req = 8'h00; en = 1'b0; delay = 2'h0;
    failures = 0; cmp_count = 0;
    void'($urandom(87405));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (n = 0; n < 5; n++) rd_chk(16'h2300 + 16'(n * 8), n == 1 ? 32'h8000 : 32'h0, RESP_OKAY);
    rd_chk(16'h2400, 32'h0, RESP_OKAY);
    for (n = 0; n < 4; n++) begin
      wr(16'h2300 + 16'(n * 8), 32'hFFFFFFFF, 4'hF);
      rd_chk(16'h2300 + 16'(n * 8), {16'h0, ctl_mask(n)}, RESP_OKAY);
      wr(16'h2300 + 16'(n * 8), n == 1 ? 32'h8000 : 32'h0, 4'h3);
    end
    wr(16'h2320, 32'hFFFF, 4'h3);
    rd_chk(16'h2320, 32'h0, RESP_OKAY);
    rd_chk(16'h2500, 32'h0, RESP_SLVERR);
    // Nesting disable freezes the status level and raises the blocked-write event.
    wr(16'h2414, 32'h2, 4'h1);
    wr(16'h2300, 32'h8000, 4'h3);
    wr(16'h2400, 32'h60, 4'h1);
    rd_chk(16'h2400, 32'h0, RESP_OKAY);
    chk(irq_q, 1'b1);
    wr(16'h2414, 32'h0, 4'h1);
    chk(irq_q, 1'b0);
    wr(16'h2414, 32'h2, 4'h1);
    wr(16'h2410, 32'h2, 4'h1);
    chk(irq_q, 1'b0);
    wr(16'h2300, 32'h0, 4'h3);
    wr(16'h2400, 32'h60, 4'h1);
    rd_chk(16'h2400, 32'h60, RESP_OKAY);
    for (n = 0; n < 8; n++) pr[n] = n == 0 ? 4'h7 : 4'($urandom_range(7, 1));
    pw = {pr[7], pr[6], pr[5], pr[4], pr[3], pr[2], pr[1], pr[0]};
    wr(16'h2408, pw, 4'hF);
    for (n = 0; n < 24; n++) begin
      lvl = 3'($urandom_range(7, 0));
      k = 3'($urandom_range(7, 0));
      if (n == 0) lvl = 3'h7;
      if (n == 0) k = 3'h0;
      wr(16'h2400, 32'(lvl) << 5, 4'h1);
      src_req <= 8'h01 << k;
      repeat (3) @(posedge aclk);
      f = fwd(pr[k], lvl);
      chk(cpu_priority_q, {1'b0, lvl});
      chk(core_irq_q, f);
      chk(core_level_q, f ? pr[k] : 4'h0);
      chk(core_vector_q, f ? {5'h0, k} : 8'h00);
      rd_chk(16'h2320, f ? {20'h0, pr[k], 5'h0, k} : 32'h0, RESP_OKAY);
      if (n % 4 == 0) begin
        wr(16'h2404, 32'h8, 4'h1);
        repeat (3) @(posedge aclk);
        chk(cpu_priority_q, {1'b1, lvl});
        chk(core_irq_q, 1'b0);
        wr(16'h2404, 32'h0, 4'h1);
      end
      src_req <= 8'h00;
      repeat (3) @(posedge aclk);
    end
    // The core now takes the interrupt and its level becomes the cpu level.
    wr(16'h2400, 32'h0, 4'h1);
    wr(16'h2410, 32'h3, 4'h1);
    wr(16'h2414, 32'h1, 4'h1);
    en <= 1'b1;
    delay <= 2'($urandom_range(3, 0));
    src_req <= 8'h04;
    for (n = 0; n < 30; n++) begin
      @(posedge aclk);
      if (!core_irq_q && cpu_priority_q === pr[2]) break;
    end
    chk(cpu_priority_q, pr[2]);
    chk(core_irq_q, 1'b0);
    chk(irq_q, 1'b1);
    rd_chk(16'h2400, 32'(pr[2][2:0]) << 5, RESP_OKAY);
    wr(16'h2410, 32'h1, 4'h1);
    chk(irq_q, 1'b0);
    conclude();
  end
endmodule : testbench
